//--- include/ucwd_regs.svh
`ifndef UCWD_REGS_SVH
`define UCWD_REGS_SVH
`define UCWD_CLK_HZ 50000000
`define UCWD_BIT_PERIOD_US 5000
`define UCWD_BIT_CYCLES (`UCWD_BIT_PERIOD_US * (`UCWD_CLK_HZ / 1000000))
`define UCWD_LAST_SUBBIT 3'h4
`define UCWD_LAST_BIT 6'h22
`define UCWD_LAST_VBIT 6'h02
`define UCWD_NUM_MODES 7'h1A
`define UCWD_WCNT_W 6
`define UCWD_IDX_SEQ 7
`define UCWD_IDX_INT 8
`define UCWD_IDX_MD_A 9
`define UCWD_IDX_MD_B 11
`define UCWD_MASK_DADDR 35'h0_1555_5478
`define UCWD_MASK_TRUE 35'h0_02AA_A000
`define UCWD_MASK_COMP 35'h7_E800_0000
`define UCWD_OFS_CTRL 8'h00
`define UCWD_OFS_PAT 8'h04
`define UCWD_OFS_DADDR 8'h08
`define UCWD_OFS_STAT 8'h0C
`define UCWD_OFS_WTAB 8'h10
`define UCWD_RST_EN 1'h1
`define UCWD_RST_VADDR 3'h0
`define UCWD_RST_TERM 7'h05
`define UCWD_RST_PAT_ONE 5'h1B
`define UCWD_RST_PAT_ZERO 5'h04
`define UCWD_RST_PAT_X 5'h15
`define UCWD_RST_WCNT 6'h01
`define UCWD_DEC_ADDR 14'h2A5C
`endif

//--- include/ucwd_pkg.sv
package ucwd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ABORT} ucwd_state_t;
  typedef enum logic [3:0] {
    CZ_NONE, CZ_GROUP, CZ_LATE, CZ_COUNT, CZ_VADDR, CZ_DADDR,
    CZ_COMPL, CZ_MODE, CZ_BUSY, CZ_NOROUT, CZ_SEQ, CZ_MODESEQ
  } ucwd_cause_t;
endpackage

//--- hw/ucwd_top.sv
`timescale 1ns/10ps
`include "ucwd_regs.svh"
// How it works
// [RULE_01] ground sends one sub-bit per reference cycle, one per millisecond
// [RULE_02] sub-bit value is the phase of the double-frequency tone
// [RULE_03] a command word is exactly 35 bits
// [RULE_04] first three bits are the vehicle address, matched against ours
// [RULE_05] 14 spread decoder address bits must equal the wired address
// [RULE_06] the 18 remaining bits are delivered to the computer adapter
// [RULE_07] bits 10 and 12 merge into the mode/data flag
// [RULE_08] bits 8 and 9 merge into the interrupt bit
// [RULE_09] seven true bits must be the exact inverse of seven complements
// [RULE_10] each bit is five sub-bits, 175 sub-bits per word
// [RULE_11] groups are classified against three configurable patterns
// [RULE_12] up to 26 mode command codes are handled
// [RULE_13] a mode command fits in a single word
// [RULE_14] data word count after a mode command depends on that mode
// [RULE_15] data word bit 8 starts at one and toggles, checked here
// [RULE_16] ground always sends bit 8 as zero in mode words
// [RULE_17] ground resends unaccepted messages, at most seven attempts
// [RULE_18] every message is reported accepted or rejected with a cause
// [RULE_19] a bit arriving later than its 5 ms period voids the message
// [RULE_20] any failed check stops decoding of that message
// [RULE_21] while a routine runs, only terminate is taken as a mode command
// [RULE_22] reset clears counters, word, sequence state and interrupt
// [RULE_23] adapter outputs hold while interrupt is up until next valid word
module ucwd_top #(
  parameter int unsigned BIT_CYCLES = `UCWD_BIT_CYCLES,
  parameter int unsigned TMR_W      = 18,
  parameter logic [13:0] DEC_ADDR   = `UCWD_DEC_ADDR
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SUBBIT_CLK,
  input  wire logic        SUBBIT_DATA,
  input  wire logic        CMD_ACK,
  output logic             CMD_INTERRUPT,
  output logic             MODE_DATA_FLAG,
  output logic      [13:0] CMD_MESSAGE,
  output logic             TLM_ACCEPT,
  output logic             TLM_REJECT,
  output logic      [3:0]  TLM_CAUSE,
  output logic             TLM_ADDR_OK
);
  localparam int unsigned WW = `UCWD_WCNT_W;
  localparam logic [TMR_W-1:0] TMR_LIM = TMR_W'(BIT_CYCLES - 1);

  function automatic logic [13:0] ucwd_gather(input logic [34:0] w, input logic [34:0] m);
    logic [13:0] r;
    r = '0;
    for (int i = 0; i < 35; i++) begin
      if (m[i]) begin
        r = {r[12:0], w[i]};
      end
    end
    return r;
  endfunction

  logic              clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  ucwd_pkg::ucwd_state_t state_r;
  logic [4:0]        grp_r, grp_nxt, pat_one_r, pat_zero_r, pat_x_r;
  logic [2:0]        sb_cnt_r, vaddr_r;
  logic [5:0]        bit_cnt_r;
  logic [TMR_W-1:0]  tmr_r;
  logic [34:0]       word_r, word_nxt;
  logic              sb_stb, grp_done, is_one, is_zero, is_x;
  logic              abort_p, done_p, enable_r, active_r, exp_seq_r, rt_done_p;
  logic [3:0]        ab_cause, ev_cause;
  logic [13:0]       daddr_w;
  logic [6:0]        true_w, comp_w, term_r;
  logic [13:0]       true_g, comp_g;
  logic              flag_w, int_w, seq_w;
  logic [WW-1:0]     words_r;
  logic [WW-1:0]     wtab_r [0:25];
  logic              acc_r, rej_r, int_r, mdf_r, aok_r, ack_r, bus_wr;
  logic [3:0]        cause_r;
  logic [13:0]       msg_r;
  logic [31:0]       rdat_r, rdat_nxt;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // two-stage synchronisers, third stage only for edge finding
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      {clk_s1, clk_s2, clk_s3, dat_s1, dat_s2} <= 5'h00;
    end else begin
      clk_s1 <= SUBBIT_CLK;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= SUBBIT_DATA;
      dat_s2 <= dat_s1;
    end
  end

  assign sb_stb   = clk_s2 & ~clk_s3 & enable_r;
  assign grp_nxt  = {grp_r[3:0], dat_s2};
  assign grp_done = sb_stb && state_r == ucwd_pkg::ST_RECV && sb_cnt_r == `UCWD_LAST_SUBBIT;
  assign is_x     = bit_cnt_r <= `UCWD_LAST_VBIT;
  assign is_one   = grp_nxt == (is_x ? pat_x_r : pat_one_r); // [RULE_11]
  assign is_zero  = grp_nxt == pat_zero_r;
  assign word_nxt = {is_one, word_r[34:1]};
  assign daddr_w  = ucwd_gather(word_nxt, `UCWD_MASK_DADDR);
  assign true_g   = ucwd_gather(word_nxt, `UCWD_MASK_TRUE);
  assign comp_g   = ucwd_gather(word_nxt, `UCWD_MASK_COMP);
  assign true_w   = true_g[6:0];
  assign comp_w   = comp_g[6:0];
  assign flag_w   = word_nxt[`UCWD_IDX_MD_A] & word_nxt[`UCWD_IDX_MD_B]; // [RULE_07]
  assign int_w    = word_nxt[`UCWD_IDX_SEQ] | word_nxt[`UCWD_IDX_INT]; // [RULE_08]
  assign seq_w    = word_nxt[`UCWD_IDX_SEQ];

  // link checks: group match, timing, vehicle address, word length
  always_comb begin
    abort_p  = 1'b0;
    done_p   = 1'b0;
    ab_cause = ucwd_pkg::CZ_NONE;
    if (state_r == ucwd_pkg::ST_RECV) begin
      if (tmr_r == TMR_LIM && !grp_done) begin
        abort_p  = 1'b1; // [RULE_19]
        ab_cause = (sb_cnt_r != 3'h0) ? ucwd_pkg::CZ_LATE : ucwd_pkg::CZ_COUNT;
      end else if (grp_done) begin
        if (!is_one && !is_zero) begin
          abort_p  = 1'b1; // [RULE_11]
          ab_cause = ucwd_pkg::CZ_GROUP;
        end else if (bit_cnt_r == `UCWD_LAST_VBIT &&
                     {word_nxt[32], word_nxt[33], word_nxt[34]} != vaddr_r) begin
          abort_p  = 1'b1; // [RULE_04]
          ab_cause = ucwd_pkg::CZ_VADDR;
        end else if (bit_cnt_r == `UCWD_LAST_BIT) begin
          done_p = 1'b1; // [RULE_03]
        end
      end
    end
  end

  // message checks on the completed word
  always_comb begin
    ev_cause = ucwd_pkg::CZ_NONE;
    if (daddr_w != DEC_ADDR) begin
      ev_cause = ucwd_pkg::CZ_DADDR; // [RULE_05]
    end else if (true_w != ~comp_w) begin
      ev_cause = ucwd_pkg::CZ_COMPL; // [RULE_09]
    end else if (flag_w) begin
      if (seq_w) begin
        ev_cause = ucwd_pkg::CZ_MODESEQ; // [RULE_16]
      end else if (true_w >= `UCWD_NUM_MODES) begin
        ev_cause = ucwd_pkg::CZ_MODE; // [RULE_12]
      end else if (active_r && true_w != term_r) begin
        ev_cause = ucwd_pkg::CZ_BUSY; // [RULE_21]
      end
    end else if (!active_r || words_r == '0) begin
      ev_cause = ucwd_pkg::CZ_NOROUT; // [RULE_14]
    end else if (seq_w != exp_seq_r) begin
      ev_cause = ucwd_pkg::CZ_SEQ; // [RULE_15]
    end
  end

  // receive state machine
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_r   <= ucwd_pkg::ST_IDLE; // [RULE_22]
      sb_cnt_r  <= 3'h0;
      bit_cnt_r <= 6'h00;
      grp_r     <= 5'h00;
      word_r    <= 35'h0_0000_0000;
      tmr_r     <= '0;
    end else begin
      case (state_r)
        ucwd_pkg::ST_IDLE: begin
          if (sb_stb) begin
            state_r   <= ucwd_pkg::ST_RECV;
            sb_cnt_r  <= 3'h1;
            bit_cnt_r <= 6'h00;
            grp_r     <= grp_nxt;
            tmr_r     <= '0;
          end
        end
        ucwd_pkg::ST_RECV: begin
          tmr_r <= tmr_r + 1'b1;
          if (sb_stb) begin
            grp_r    <= grp_nxt;
            sb_cnt_r <= grp_done ? 3'h0 : sb_cnt_r + 3'h1; // [RULE_10]
          end
          if (abort_p) begin
            state_r <= ucwd_pkg::ST_ABORT; // [RULE_20]
            tmr_r   <= '0;
          end else if (grp_done) begin
            tmr_r     <= '0;
            word_r    <= word_nxt;
            bit_cnt_r <= bit_cnt_r + 6'h01;
            if (done_p) begin
              state_r <= ucwd_pkg::ST_IDLE;
            end
          end
        end
        ucwd_pkg::ST_ABORT: begin
          // wait for a quiet bit period before listening again
          tmr_r    <= sb_stb ? '0 : tmr_r + 1'b1;
          sb_cnt_r <= 3'h0;
          if (tmr_r == TMR_LIM) begin
            state_r <= ucwd_pkg::ST_IDLE;
          end
        end
        default: state_r <= ucwd_pkg::ST_IDLE;
      endcase
    end
  end

  // routine and sequence tracking
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      active_r  <= 1'b0; // [RULE_22]
      exp_seq_r <= 1'b1;
      words_r   <= '0;
    end else if (done_p && ev_cause == ucwd_pkg::CZ_NONE) begin
      if (flag_w && true_w == term_r) begin
        active_r <= 1'b0;
        words_r  <= '0;
      end else if (flag_w) begin
        active_r  <= 1'b1; // [RULE_13]
        words_r   <= wtab_r[true_w[4:0]]; // [RULE_14]
        exp_seq_r <= 1'b1; // [RULE_15]
      end else begin
        words_r   <= words_r - 1'b1;
        exp_seq_r <= ~exp_seq_r; // [RULE_15]
      end
    end else if (rt_done_p) begin
      active_r <= 1'b0; // [RULE_21]
    end
  end

  // adapter and telemetry outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      acc_r   <= 1'b0;
      rej_r   <= 1'b0;
      int_r   <= 1'b0; // [RULE_22]
      mdf_r   <= 1'b0;
      aok_r   <= 1'b0;
      msg_r   <= 14'h0000;
      cause_r <= ucwd_pkg::CZ_NONE;
    end else begin
      acc_r <= done_p && ev_cause == ucwd_pkg::CZ_NONE; // [RULE_18]
      rej_r <= abort_p || (done_p && ev_cause != ucwd_pkg::CZ_NONE);
      if (abort_p) begin
        cause_r <= ab_cause;
        aok_r   <= 1'b0;
      end else if (done_p) begin
        cause_r <= ev_cause;
        aok_r   <= daddr_w == DEC_ADDR;
      end
      if (done_p && ev_cause == ucwd_pkg::CZ_NONE) begin
        mdf_r <= flag_w; // [RULE_23]
        msg_r <= {true_w, comp_w}; // [RULE_06]
        int_r <= int_w | int_r;
      end else if (CMD_ACK) begin
        int_r <= 1'b0;
      end
    end
  end

  assign CMD_INTERRUPT  = int_r;
  assign MODE_DATA_FLAG = mdf_r;
  assign CMD_MESSAGE    = msg_r;
  assign TLM_ACCEPT     = acc_r;
  assign TLM_REJECT     = rej_r;
  assign TLM_CAUSE      = cause_r;
  assign TLM_ADDR_OK    = aok_r;

  // wishbone slave
  // write lands at the edge where the master sees ack
  assign bus_wr    = WB_CYC_I & WB_STB_I & WB_WE_I & ack_r;
  assign rt_done_p = bus_wr && WB_ADR_I == `UCWD_OFS_CTRL && WB_SEL_I[0] && WB_DAT_I[1];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      enable_r   <= `UCWD_RST_EN;
      vaddr_r    <= `UCWD_RST_VADDR;
      term_r     <= `UCWD_RST_TERM;
      pat_one_r  <= `UCWD_RST_PAT_ONE;
      pat_zero_r <= `UCWD_RST_PAT_ZERO;
      pat_x_r    <= `UCWD_RST_PAT_X;
      for (int i = 0; i < 26; i++) begin
        wtab_r[i] <= `UCWD_RST_WCNT;
      end
    end else if (bus_wr) begin
      case (WB_ADR_I)
        `UCWD_OFS_CTRL: begin
          if (WB_SEL_I[0]) begin
            enable_r <= WB_DAT_I[0];
            vaddr_r  <= WB_DAT_I[4:2];
          end
          if (WB_SEL_I[1]) begin
            term_r <= WB_DAT_I[14:8];
          end
        end
        `UCWD_OFS_PAT: begin
          if (WB_SEL_I[0]) pat_one_r <= WB_DAT_I[4:0];
          if (WB_SEL_I[1]) pat_zero_r <= WB_DAT_I[12:8];
          if (WB_SEL_I[2]) pat_x_r <= WB_DAT_I[20:16];
        end
        `UCWD_OFS_WTAB: begin
          if (WB_SEL_I[1:0] == 2'h3 && WB_DAT_I[4:0] < 5'h1A) begin
            wtab_r[WB_DAT_I[4:0]] <= WB_DAT_I[13:8];
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    case (WB_ADR_I)
      `UCWD_OFS_CTRL:  rdat_nxt = {17'h0, term_r, 3'h0, vaddr_r, 1'b0, enable_r};
      `UCWD_OFS_PAT:   rdat_nxt = {11'h0, pat_x_r, 3'h0, pat_zero_r, 3'h0, pat_one_r};
      `UCWD_OFS_DADDR: rdat_nxt = {18'h0, DEC_ADDR};
      `UCWD_OFS_STAT:  rdat_nxt = {14'h0, state_r, 2'h0, words_r,
                                   cause_r, aok_r, int_r, exp_seq_r, active_r};
      default:         rdat_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= WB_CYC_I & WB_STB_I & ~ack_r;
      rdat_r <= rdat_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  sequence late_s;
    state_r == ucwd_pkg::ST_RECV && tmr_r == TMR_LIM && !grp_done;
  endsequence
  sequence reject_s;
    rej_r && (cause_r == ucwd_pkg::CZ_LATE || cause_r == ucwd_pkg::CZ_COUNT);
  endsequence

  word_len_a: // [RULE_03]
  assert property (acc_r |-> $past(done_p) && $past(bit_cnt_r) == `UCWD_LAST_BIT)
    else $error("accept without a full 35-bit word");
  veh_addr_a: // [RULE_04]
  assert property (acc_r |-> {word_r[0], word_r[1], word_r[2]} == $past(vaddr_r))
    else $error("accepted word with wrong vehicle address");
  dec_addr_a: // [RULE_05]
  assert property (acc_r |-> ucwd_gather(word_r, `UCWD_MASK_DADDR) == DEC_ADDR)
    else $error("accepted word with wrong decoder address");
  compl_chk_a: // [RULE_09]
  assert property (acc_r |-> msg_r[13:7] == ~msg_r[6:0])
    else $error("accepted word with bad complement");
  flag_merge_a: // [RULE_07]
  assert property (acc_r |-> mdf_r == (word_r[9] & word_r[11]))
    else $error("mode/data flag not merged from bits 10 and 12");
  int_merge_a: // [RULE_08]
  assert property (acc_r && (word_r[7] | word_r[8]) |-> int_r)
    else $error("interrupt not raised for accepted word");
  out_hold_a: // [RULE_23]
  assert property (int_r && !acc_r |-> $stable(msg_r) && $stable(mdf_r))
    else $error("adapter outputs changed while interrupt pending");
  late_bit_a: // [RULE_19]
  assert property (late_s |=> state_r == ucwd_pkg::ST_ABORT ##0 reject_s)
    else $error("late bit not rejected");
  stop_dec_a: // [RULE_20]
  assert property (abort_p |=> (state_r == ucwd_pkg::ST_ABORT && !acc_r)[*2])
    else $error("decoding continued after a failed check");
  report_a: // [RULE_18]
  assert property (done_p |=> acc_r ^ rej_r)
    else $error("message neither accepted nor rejected");
  mode_range_a: // [RULE_12]
  assert property (acc_r && mdf_r |-> msg_r[13:7] < `UCWD_NUM_MODES)
    else $error("mode code out of range accepted");
  busy_a: // [RULE_21]
  assert property (acc_r && mdf_r && msg_r[13:7] != $past(term_r) |-> !$past(active_r))
    else $error("mode command accepted during a routine");
  seq_bit_a: // [RULE_15]
  assert property (acc_r && !mdf_r |-> word_r[7] == $past(exp_seq_r))
    else $error("data word accepted out of sequence");
endmodule

//--- sim/ucwd_ground_model.sv
`timescale 1ns/10ps
`include "ucwd_regs.svh"
module ucwd_ground_model (
  input  wire logic        start,
  input  wire logic [1:35] word,
  input  wire logic [7:0]  stop_at,
  input  wire logic [7:0]  bad_bit,
  output logic             sck,
  output logic             sdat,
  output logic             busy
);
  logic [4:0] pat;
  int         n;
  initial begin
    sck = 1'b0;
    sdat = 1'b1;
    busy = 1'b0;
  end
  // link clock stands still between frames, phase unrelated to the core clock
  always @(posedge start) begin
    busy = 1'b1;
    #13;
    for (int i = 0; i < 175 && i < stop_at; i++) begin
      n = i / 5 + 1;
      if (n <= 3) begin
        pat = word[n] ? `UCWD_RST_PAT_X : `UCWD_RST_PAT_ZERO;
      end else begin
        pat = word[n] ? `UCWD_RST_PAT_ONE : `UCWD_RST_PAT_ZERO;
      end
      if (n == bad_bit) begin
        pat = pat ^ 5'h01;
      end
      sdat = pat[4 - i % 5];
      #40 sck = 1'b1;
      #80 sck = 1'b0;
      #40;
    end
    // released line shows the inverse of the last value
    sdat = ~sdat;
    busy = 1'b0;
  end
endmodule

//--- sim/ucwd_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module ucwd_tb;
  localparam logic [13:0] DA = 14'h2A5C;
  logic        CORE_CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, SUBBIT_CLK, SUBBIT_DATA, CMD_ACK;
  logic        CMD_INTERRUPT, MODE_DATA_FLAG, TLM_ACCEPT, TLM_REJECT, TLM_ADDR_OK, WB_ACK_O;
  logic [7:0]  WB_ADR_I, stop_at, bad_bit;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic [3:0]  WB_SEL_I, TLM_CAUSE;
  logic [13:0] CMD_MESSAGE, exp_msg;
  logic [1:35] word;
  logic        start, busy;
  int          failures, cmp_count;

  ucwd_top #(.BIT_CYCLES(60)) i_ucwd_top (
    .CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SUBBIT_CLK(SUBBIT_CLK),
    .SUBBIT_DATA(SUBBIT_DATA), .CMD_ACK(CMD_ACK), .CMD_INTERRUPT(CMD_INTERRUPT),
    .MODE_DATA_FLAG(MODE_DATA_FLAG), .CMD_MESSAGE(CMD_MESSAGE), .TLM_ACCEPT(TLM_ACCEPT),
    .TLM_REJECT(TLM_REJECT), .TLM_CAUSE(TLM_CAUSE), .TLM_ADDR_OK(TLM_ADDR_OK));
  ucwd_ground_model i_ucwd_ground_model (
    .start(start), .word(word), .stop_at(stop_at), .bad_bit(bad_bit),
    .sck(SUBBIT_CLK), .sdat(SUBBIT_DATA), .busy(busy));

  initial CORE_CLK = 1'b0;
  always #10 CORE_CLK = ~CORE_CLK;

  task automatic test_done;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge CORE_CLK);
    end while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  function automatic logic [1:35] mk(input logic [2:0] va, input logic md, sq,
                                     input logic [6:0] cd, cx, input logic [13:0] dx);
    logic [1:35] w;
    int          dp[14];
    int          cp[7];
    dp = '{4, 5, 6, 7, 11, 13, 15, 17, 19, 21, 23, 25, 27, 29};
    cp = '{28, 30, 31, 32, 33, 34, 35};
    w = '0;
    w[1:3] = va;
    w[8] = sq;
    w[9] = 1'b1;
    w[10] = md;
    w[12] = md;
    for (int i = 0; i < 14; i++) w[dp[i]] = DA[13 - i] ^ dx[13 - i];
    for (int i = 0; i < 7; i++) begin
      w[14 + 2 * i] = cd[6 - i];
      w[cp[i]] = ~cd[6 - i] ^ cx[6 - i];
    end
    return w;
  endfunction

  task automatic msg(input logic [2:0] va, input logic md, sq, input logic [6:0] cd, cx,
                     input logic [13:0] dx, input logic [7:0] stp, bb,
                     input ucwd_pkg::ucwd_cause_t ec);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    word <= mk(va, md, sq, cd, cx, dx);
    stop_at <= stp;
    bad_bit <= bb;
    start <= 1'b1;
    @(posedge CORE_CLK);
    start <= 1'b0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (TLM_ACCEPT !== 1'b1 && TLM_REJECT !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
    end
    `CHK(TLM_ACCEPT, ec == ucwd_pkg::CZ_NONE)
    `CHK(TLM_REJECT, ec != ucwd_pkg::CZ_NONE)
    `CHK(TLM_CAUSE, ec)
    if (ec == ucwd_pkg::CZ_NONE) begin
      exp_msg = {cd, ~cd};
      `CHK(MODE_DATA_FLAG, md)
      `CHK(CMD_INTERRUPT, 1'b1)
      `CHK(TLM_ADDR_OK, 1'b1)
    end
    if (ec == ucwd_pkg::CZ_DADDR) begin
      `CHK(TLM_ADDR_OK, 1'b0)
    end
    `CHK(CMD_MESSAGE, exp_msg)
    wait (busy === 1'b0);
    repeat (100) @(posedge CORE_CLK);
  endtask

  task automatic send_mode(input logic [6:0] cd, input ucwd_pkg::ucwd_cause_t ec);
    msg(3'h3, 1'b1, 1'b0, cd, 7'h00, 14'h0000, 8'hAF, 8'h00, ec);
  endtask

  task automatic send_data(input logic sq, input ucwd_pkg::ucwd_cause_t ec);
    msg(3'h3, 1'b0, sq, 7'h55, 7'h00, 14'h0000, 8'hAF, 8'h00, ec);
  endtask

  task automatic ack_int;
    @(posedge CORE_CLK);
    CMD_ACK <= 1'b1;
    @(posedge CORE_CLK);
    CMD_ACK <= 1'b0;
    @(negedge CORE_CLK);
    `CHK(CMD_INTERRUPT, 1'b0)
  endtask

  initial begin
    repeat (100000) @(posedge CORE_CLK);
    failures++;
    test_done;
  end

  initial begin
    {WB_CYC_I, WB_STB_I, WB_WE_I, CMD_ACK, start} = '0;
    RST = 1'b1;
    WB_ADR_I = 8'h00;
    WB_DAT_I = 32'h0000_0000;
    WB_SEL_I = 4'hF;
    word = '0;
    stop_at = 8'hAF;
    bad_bit = 8'h00;
    failures = 0;
    cmp_count = 0;
    exp_msg = 14'h0000;
    repeat (12) @(posedge CORE_CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    `CHK(CMD_INTERRUPT, 1'b0)
    rdc(8'h00, 32'h0000_0501);
    rdc(8'h04, 32'h0015_041B);
    wb(1'b1, 8'h08, 32'h0000_0000);
    rdc(8'h08, 32'h0000_2A5C);
    rdc(8'h20, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_050D);
    rdc(8'h00, 32'h0000_050D);
    wb(1'b1, 8'h10, 32'h0000_0204);
    send_mode(7'h04, ucwd_pkg::CZ_NONE);
    ack_int;
    send_mode(7'h07, ucwd_pkg::CZ_BUSY);
    send_data(1'b1, ucwd_pkg::CZ_NONE);
    send_data(1'b1, ucwd_pkg::CZ_SEQ);
    send_data(1'b0, ucwd_pkg::CZ_NONE);
    send_data(1'b1, ucwd_pkg::CZ_NOROUT);
    send_mode(7'h05, ucwd_pkg::CZ_NONE);
    send_data(1'b1, ucwd_pkg::CZ_NOROUT);
    send_mode(7'h1A, ucwd_pkg::CZ_MODE);
    send_mode(7'h19, ucwd_pkg::CZ_NONE);
    wb(1'b1, 8'h00, 32'h0000_050F);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(rd[0], 1'b0)
    msg(3'h3, 1'b1, 1'b1, 7'h02, 7'h00, 14'h0000, 8'hAF, 8'h00, ucwd_pkg::CZ_MODESEQ);
    msg(3'h0, 1'b1, 1'b0, 7'h02, 7'h00, 14'h0000, 8'hAF, 8'h00, ucwd_pkg::CZ_VADDR);
    msg(3'h3, 1'b1, 1'b0, 7'h02, 7'h00, 14'h0001, 8'hAF, 8'h00, ucwd_pkg::CZ_DADDR);
    msg(3'h3, 1'b1, 1'b0, 7'h02, 7'h10, 14'h0000, 8'hAF, 8'h00, ucwd_pkg::CZ_COMPL);
    msg(3'h3, 1'b1, 1'b0, 7'h02, 7'h00, 14'h0000, 8'hAF, 8'h14, ucwd_pkg::CZ_GROUP);
    msg(3'h3, 1'b1, 1'b0, 7'h02, 7'h00, 14'h0000, 8'h0F, 8'h00, ucwd_pkg::CZ_COUNT);
    msg(3'h3, 1'b1, 1'b0, 7'h02, 7'h00, 14'h0000, 8'h11, 8'h00, ucwd_pkg::CZ_LATE);
    send_mode(7'h02, ucwd_pkg::CZ_NONE);
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(negedge CORE_CLK);
    `CHK(CMD_INTERRUPT, 1'b0)
    `CHK(CMD_MESSAGE, 14'h0000)
    test_done;
  end
endmodule
